/* hw/rmdec_top.sv */
// Register map decoder and channel-banked register file
// How it works
// - Global registers exist once and are reachable whatever channel is active.
// - Each per-channel register has one copy per channel and only the active channel's copy is accessed.
// - Outside interrupt context the host sets the active channel by writing channel_select, which holds until rewritten.
// - During interrupt service and DMA the device supplies the active channel itself.
// - Some per-channel locations mean different registers in async, sync and PPP operation.
// - Every register decodes at one address in the little-endian map and another in the big-endian map.
// - Registers whose function is missing from the loaded control program are not valid.
// - A high byte-order strap selects the little-endian map and a low strap the big-endian map.
`timescale 1ns/100ps
module rmdec_top
    import rmdec_pkg::*;
#(
    parameter int NCH = N_CHAN
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  byte_order_strap,
    input  wire logic                  host_rd,
    input  wire logic                  host_wr,
    input  wire logic [7:0]            host_addr,
    input  wire logic [DATA_W-1:0]     host_wdata,
    output logic      [DATA_W-1:0]     host_rdata,
    output logic                       host_ack,
    input  wire logic                  ctx_active,
    input  wire logic [CH_W-1:0]       ctx_channel,
    input  wire logic [N_GROUPS-1:0]   func_present,
    input  wire logic [NCH*DATA_W-1:0] chan_status,
    output logic      [CH_W-1:0]       active_channel,
    output logic                       little_endian_map
);

    // Class of a location against the active protocol
    function automatic logic class_ok(input logic [2:0] cl,
                                      input rmdec_proto_e pr);
        logic ok;
        ok = 1'b0;
        case (cl)
            CL_ANY:    ok = 1'b1;
            CL_ASYNC:  ok = (pr == PROTO_ASYNC);
            CL_SYNC:   ok = (pr == PROTO_SYNC);
            CL_PPP:    ok = (pr == PROTO_PPP);
            CL_NONPPP: ok = (pr != PROTO_PPP);
            default:   ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Returns {hit, slot}; only one slot can match for one protocol
    function automatic logic [SLOT_W:0] decode(
        input logic [7:0]          a,
        input logic                le,
        input rmdec_proto_e        pr,
        input logic [N_GROUPS-1:0] fp);
        logic [SLOT_W:0] r;
        logic [7:0]      loc;
        r = '0;
        loc = '0;
        for (int i = 0; i < N_SLOTS; i++) begin
            loc = le ? LE_ADDR[i] : BE_ADDR[i];
            if (loc == a && class_ok(SLOT_CLASS[i], pr)
                && fp[SLOT_GROUP[i]]) begin
                r = {1'b1, SLOT_W'(i)};
            end
        end
        return r;
    endfunction

    // Strap comes from a pin: two flops before use
    logic strap_meta_q;
    logic strap_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_meta_q <= STRAP_RESET;
            strap_q      <= STRAP_RESET;
        end else begin
            strap_meta_q <= byte_order_strap;
            strap_q      <= strap_meta_q;
        end
    end

    // Global registers and the per-channel mode registers
    logic [CH_W-1:0]   chsel_q;
    logic [DATA_W-1:0] fwrev_q;
    logic [DATA_W-1:0] cmr_q [NCH];

    // Active channel and its protocol
    logic [CH_W-1:0] act_ch;
    rmdec_proto_e    proto;
    logic [SLOT_W:0] dec;
    logic            hit;
    logic [SLOT_W-1:0] slot;
    logic            is_global;
    logic            rd_go;
    logic            wr_go;

    assign act_ch = ctx_active ? ctx_channel : chsel_q;
    assign proto  = rmdec_proto_e'(cmr_q[act_ch][PROTO_MSB:PROTO_LSB]);
    assign dec    = decode(host_addr, strap_q, proto, func_present);
    assign hit    = dec[SLOT_W];
    assign slot   = dec[SLOT_W-1:0];
    assign is_global = hit && (slot >= SLOT_FIRST_GL);
    assign rd_go  = host_rd;
    // A read and write together: the read is taken, the write dropped
    assign wr_go  = host_wr && !host_rd && hit;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chsel_q <= CHSEL_RESET;
        end else if (wr_go && slot == SLOT_CHSEL) begin
            // Held until the host writes it again, even across contexts
            chsel_q <= host_wdata[CH_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fwrev_q <= FWREV_RESET;
        end else if (wr_go && slot == SLOT_FWREV) begin
            fwrev_q <= host_wdata;
        end
    end

    // Mode registers kept in flops: they steer the decode every cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < NCH; c++) begin
                cmr_q[c] <= CMR_RESET;
            end
        end else if (wr_go && slot == SLOT_CMR) begin
            cmr_q[act_ch] <= host_wdata;
        end
    end

    // Banked storage: channel number forms the upper address bits
    logic              mem_we;
    logic [7:0]        mem_addr;
    logic [DATA_W-1:0] mem_rdata;

    assign mem_we   = wr_go && !is_global && slot != SLOT_CMR
                      && slot != SLOT_CSR;
    assign mem_addr = {act_ch, slot};

    rmdec_mem #(
        .WIDTH (DATA_W),
        .DEPTH (MEM_DEPTH),
        .AW    (8)
    ) u_mem (
        .clk     (clk),
        .we      (mem_we),
        .addr    (mem_addr),
        .wdata   (host_wdata),
        .rdata_q (mem_rdata)
    );

    // Read value for locations not in the memory
    logic [DATA_W-1:0] direct_d;
    logic              from_mem_d;

    always_comb begin
        direct_d   = READ_ZERO;
        from_mem_d = 1'b0;
        if (hit) begin
            if (slot == SLOT_CHSEL) begin
                direct_d = {{(DATA_W-CH_W){1'b0}}, chsel_q};
            end else if (slot == SLOT_FWREV) begin
                direct_d = fwrev_q;
            end else if (slot == SLOT_CMR) begin
                direct_d = cmr_q[act_ch];
            end else if (slot == SLOT_CSR) begin
                direct_d = chan_status[act_ch*DATA_W +: DATA_W];
            end else begin
                from_mem_d = 1'b1;
            end
        end
    end

    // Two-stage answer: memory read data is registered once
    logic              pend_q;
    logic              from_mem_q;
    logic [DATA_W-1:0] direct_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q     <= 1'b0;
            from_mem_q <= 1'b0;
            direct_q   <= READ_ZERO;
        end else begin
            pend_q     <= host_rd || host_wr;
            from_mem_q <= rd_go && from_mem_d;
            direct_q   <= rd_go ? direct_d : READ_ZERO;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_ack   <= 1'b0;
            host_rdata <= READ_ZERO;
        end else begin
            host_ack   <= pend_q;
            host_rdata <= from_mem_q ? mem_rdata : direct_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_channel    <= CHSEL_RESET;
            little_endian_map <= STRAP_RESET;
        end else begin
            active_channel    <= act_ch;
            little_endian_map <= strap_q;
        end
    end

    // Check helpers: built from the map tables, not from the decoder
    logic [7:0]        chsel_loc;
    logic [7:0]        fwrev_loc;
    logic [7:0]        spc_loc;
    logic [CH_W-1:0]   wdata_ch;
    logic [DATA_W-1:0] csr_now;

    assign chsel_loc = strap_q ? LE_ADDR[SLOT_CHSEL] : BE_ADDR[SLOT_CHSEL];
    assign fwrev_loc = strap_q ? LE_ADDR[SLOT_FWREV] : BE_ADDR[SLOT_FWREV];
    assign spc_loc   = strap_q ? LE_ADDR[SLOT_SPC_LO] : BE_ADDR[SLOT_SPC_LO];
    assign wdata_ch  = host_wdata[CH_W-1:0];
    assign csr_now   = chan_status[act_ch*DATA_W +: DATA_W];

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ack_timing_a: assert property (
        (host_rd || host_wr) |-> ##2 host_ack)
        else $error("Access not answered two cycles later");

    unmapped_zero_a: assert property (
        (host_rd && !hit) |-> ##2 (host_rdata == READ_ZERO))
        else $error("Unmapped read did not return zero");

    unmapped_nowrite_a: assert property (
        (host_wr && !hit) |=> $stable(chsel_q) && $stable(fwrev_q))
        else $error("Write to unmapped address changed state");

    chsel_hold_a: assert property (
        !(wr_go && slot == SLOT_CHSEL) |=> $stable(chsel_q))
        else $error("Channel select changed without host write");

    chsel_read_a: assert property (
        (host_rd && hit && slot == SLOT_CHSEL) |-> ##2
        (host_rdata[CH_W-1:0] == $past(chsel_q, 2)))
        else $error("Channel select readback wrong");

    ctx_channel_a: assert property (
        ctx_active |=> (active_channel == $past(ctx_channel)))
        else $error("Context channel not used");

    host_channel_a: assert property (
        !ctx_active |=> (active_channel == $past(chsel_q)))
        else $error("Host channel not used outside context");

    bank_select_a: assert property (
        mem_we |-> (mem_addr[7:SLOT_W] == act_ch))
        else $error("Write reached wrong channel bank");

    alias_proto_a: assert property (
        (mem_we && slot >= SLOT_SPC_LO && slot <= SLOT_SPC_HI)
        |-> (proto == PROTO_ASYNC))
        else $error("Special character written outside async");

    func_valid_a: assert property (
        (wr_go || (host_rd && hit)) |-> func_present[SLOT_GROUP[slot]])
        else $error("Access to register absent from program");

    le_map_a: assert property (
        (strap_q && host_rd && func_present[GR_CORE]
         && host_addr == LE_ADDR[SLOT_CHSEL]) |-> (hit && slot == SLOT_CHSEL))
        else $error("Little-endian map did not decode");

    be_map_a: assert property (
        (!strap_q && host_rd && func_present[GR_CORE]
         && host_addr == BE_ADDR[SLOT_CHSEL]) |-> (hit && slot == SLOT_CHSEL))
        else $error("Big-endian map did not decode");

    fwrev_read_a: assert property (
        (host_rd && func_present[GR_CORE] && host_addr == fwrev_loc)
        |-> ##2 (host_rdata == $past(fwrev_q, 2)))
        else $error("Firmware revision readback wrong");

    func_absent_a: assert property (
        (host_rd && !func_present[GR_CORE]
         && (host_addr == chsel_loc || host_addr == fwrev_loc))
        |-> ##2 (host_rdata == READ_ZERO))
        else $error("Global read with core program absent");

    chsel_write_a: assert property (
        (host_wr && !host_rd && func_present[GR_CORE]
         && host_addr == chsel_loc) |=> (chsel_q == $past(wdata_ch)))
        else $error("Channel select write not taken");

    chsel_range_a: assert property (
        (host_rd && hit && slot == SLOT_CHSEL)
        |-> ##2 (host_rdata[DATA_W-1:CH_W] == '0))
        else $error("Channel select upper bits not zero");

    mode_write_a: assert property (
        (wr_go && slot == SLOT_CMR)
        |=> (cmr_q[$past(act_ch)] == $past(host_wdata)))
        else $error("Mode write missed the active channel");

    status_read_a: assert property (
        (host_rd && hit && slot == SLOT_CSR)
        |-> ##2 (host_rdata == $past(csr_now, 2)))
        else $error("Status read not from active channel");

    ctx_bank_a: assert property (
        (ctx_active && mem_we) |-> (mem_addr[7:SLOT_W] == ctx_channel))
        else $error("Context write reached wrong bank");

    alias_none_a: assert property (
        (host_rd && proto == PROTO_NONE && host_addr == spc_loc) |-> !hit)
        else $error("Alias decoded with no protocol");

    alias_async_a: assert property (
        (host_rd && proto == PROTO_ASYNC && func_present[GR_ASYNC]
         && host_addr == spc_loc) |-> (hit && slot == SLOT_SPC_LO))
        else $error("Async alias did not decode");

    map_follow_a: assert property (
        little_endian_map == $past(strap_q))
        else $error("Map flag does not follow strap");

    ack_only_a: assert property (
        !(host_rd || host_wr) |-> ##2 !host_ack)
        else $error("Acknowledge without access");

    cov_ctx_write_c: cover property (ctx_active && mem_we);
    cov_be_read_c:   cover property (!strap_q && host_rd && hit);
    cov_ppp_alias_c: cover property (proto == PROTO_PPP && mem_we);
    cov_unmapped_c:  cover property (host_rd && !hit);
    cov_none_read_c: cover property (proto == PROTO_NONE && host_rd);

endmodule // rmdec_top

/* hw/rmdec_pkg.sv */
// Constants and tables for the multichannel register map decoder
package rmdec_pkg;

    localparam int N_CHAN    = 4;
    localparam int CH_W      = 2;
    localparam int DATA_W    = 8;
    localparam int SLOT_W    = 6;
    localparam int N_SLOTS   = 42;
    localparam int N_PERCH   = 40;
    localparam int N_GROUPS  = 6;
    localparam int MEM_DEPTH = 256;

    // Protocol held in the low field of each channel's mode register
    typedef enum logic [1:0] {
        PROTO_ASYNC,
        PROTO_SYNC,
        PROTO_PPP,
        PROTO_NONE
    } rmdec_proto_e;

    localparam int PROTO_LSB = 0;
    localparam int PROTO_MSB = 1;

    // Which protocols a location answers in
    localparam logic [2:0] CL_ANY    = 3'h0;
    localparam logic [2:0] CL_ASYNC  = 3'h1;
    localparam logic [2:0] CL_SYNC   = 3'h2;
    localparam logic [2:0] CL_PPP    = 3'h3;
    localparam logic [2:0] CL_NONPPP = 3'h4;

    // Function groups of the loaded control program
    localparam logic [2:0] GR_CORE  = 3'h0;
    localparam logic [2:0] GR_ASYNC = 3'h1;
    localparam logic [2:0] GR_SYNC  = 3'h2;
    localparam logic [2:0] GR_PPP   = 3'h3;
    localparam logic [2:0] GR_CLOCK = 3'h4;
    localparam logic [2:0] GR_MODEM = 3'h5;

    // Slots of special meaning; slots 40 and up are global
    localparam logic [5:0] SLOT_CMR      = 6'h09;
    localparam logic [5:0] SLOT_CSR      = 6'h0a;
    localparam logic [5:0] SLOT_SPC_LO   = 6'h0d;
    localparam logic [5:0] SLOT_SPC_HI   = 6'h10;
    localparam logic [5:0] SLOT_FIRST_GL = 6'h28;
    localparam logic [5:0] SLOT_FWREV    = 6'h28;
    localparam logic [5:0] SLOT_CHSEL    = 6'h29;

    // Slot order: channel_option_7 tx_mapped_char_2 ccr special_transmit_command channel_option_1..channel_option_5 cmr csr channel_option_6 tx_mapped_char_1
    // special_char_1..4 rx_frame_address_1..4 tx_ctrl_char_map_0..3 scrl special_char_range_high rx_ctrl_char_map_0..3 literal_next_char tx_mapped_char_3
    // rx_baud_period rx_clock_option tx_baud_period tx_clock_option crc_poly_select rts dtr fwrev chsel
    localparam logic [7:0] LE_ADDR [N_SLOTS] = '{
        8'h04, 8'h04, 8'h10, 8'h11, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
        8'h18, 8'h19, 8'h1b, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h1c,
        8'h1d, 8'h1e, 8'h1f, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21,
        8'h20, 8'h21, 8'h22, 8'h23, 8'h2d, 8'h2d, 8'hc9, 8'hca, 8'hc1,
        8'hc2, 8'hd4, 8'hdc, 8'hdd, 8'h82, 8'hec};
    localparam logic [7:0] BE_ADDR [N_SLOTS] = '{
        8'h07, 8'h07, 8'h13, 8'h12, 8'h10, 8'h17, 8'h16, 8'h15, 8'h14,
        8'h1b, 8'h1a, 8'h18, 8'h18, 8'h1f, 8'h1e, 8'h1d, 8'h1c, 8'h1f,
        8'h1e, 8'h1d, 8'h1c, 8'h1f, 8'h1e, 8'h1d, 8'h1c, 8'h23, 8'h22,
        8'h23, 8'h22, 8'h21, 8'h20, 8'h2e, 8'h2e, 8'hcb, 8'hc8, 8'hc3,
        8'hc0, 8'hd6, 8'hde, 8'hdf, 8'h81, 8'hee};
    localparam logic [2:0] SLOT_CLASS [N_SLOTS] = '{
        CL_NONPPP, CL_PPP, CL_ANY, CL_ANY, CL_ANY, CL_ANY, CL_ANY,
        CL_ANY, CL_ANY, CL_ANY, CL_ANY, CL_NONPPP, CL_PPP,
        CL_ASYNC, CL_ASYNC, CL_ASYNC, CL_ASYNC,
        CL_SYNC, CL_SYNC, CL_SYNC, CL_SYNC,
        CL_PPP, CL_PPP, CL_PPP, CL_PPP, CL_ASYNC, CL_ASYNC,
        CL_PPP, CL_PPP, CL_PPP, CL_PPP, CL_ASYNC, CL_PPP,
        CL_ANY, CL_ANY, CL_ANY, CL_ANY, CL_SYNC, CL_ANY, CL_ANY,
        CL_ANY, CL_ANY};
    localparam logic [2:0] SLOT_GROUP [N_SLOTS] = '{
        GR_CORE, GR_PPP, GR_CORE, GR_CORE, GR_CORE, GR_CORE, GR_CORE,
        GR_CORE, GR_CORE, GR_CORE, GR_CORE, GR_CORE, GR_PPP,
        GR_ASYNC, GR_ASYNC, GR_ASYNC, GR_ASYNC,
        GR_SYNC, GR_SYNC, GR_SYNC, GR_SYNC,
        GR_PPP, GR_PPP, GR_PPP, GR_PPP, GR_ASYNC, GR_ASYNC,
        GR_PPP, GR_PPP, GR_PPP, GR_PPP, GR_ASYNC, GR_PPP,
        GR_CLOCK, GR_CLOCK, GR_CLOCK, GR_CLOCK, GR_SYNC, GR_MODEM,
        GR_MODEM, GR_CORE, GR_CORE};

    localparam logic [7:0] CMR_RESET   = 8'h00;
    localparam logic [7:0] FWREV_RESET = 8'h00;
    localparam logic [1:0] CHSEL_RESET = 2'h0;
    localparam logic       STRAP_RESET = 1'b1;
    localparam logic [7:0] READ_ZERO   = 8'h00;

endpackage

/* hw/rmdec_mem.sv */
// Per-channel register storage with registered read data
`timescale 1ns/100ps
module rmdec_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic             clk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] rdata_q
);

    logic [WIDTH-1:0] store [DEPTH];

    // Contents undefined until software programs them
    always_ff @(posedge clk) begin
        if (we) begin
            store[addr] <= wdata;
        end
        rdata_q <= store[addr];
    end

endmodule // rmdec_mem

/* dv/rmdec_host.sv */
// Host processor model for the register port
`timescale 1ns/100ps
module rmdec_host (
    input  wire logic       clk,
    output logic            host_rd,
    output logic            host_wr,
    output logic [7:0]      host_addr,
    output logic [7:0]      host_wdata,
    input  wire logic [7:0] host_rdata,
    input  wire logic       host_ack
);
    initial begin
        host_rd    = 1'b0;
        host_wr    = 1'b0;
        host_addr  = 8'h00;
        host_wdata = 8'h00;
    end

    // One access; channel_select writes pick the channel
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q,
                          output int lat);
        q   = 8'h00;
        lat = 0;
        @(negedge clk);
        host_addr  = a;
        host_wdata = d;
        host_rd    = ~wr;
        host_wr    = wr;
        @(negedge clk);
        host_rd    = 1'b0;
        host_wr    = 1'b0;
        // Released lines show the inverse, never a stale value
        host_addr  = ~a;
        host_wdata = ~d;
        for (int i = 1; i <= 6; i++) begin
            @(negedge clk);
            if (host_ack === 1'b1) begin
                q   = host_rdata;
                // Ack stands here, after the edge that raised it
                lat = i + 1;
                break;
            end
        end
    endtask
endmodule // rmdec_host

/* dv/tb.sv */
// Self-checking testbench for the register map decoder
`timescale 1ns/100ps
module tb
    import rmdec_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst_n;
    logic              strap;
    logic              host_rd;
    logic              host_wr;
    logic [7:0]        host_addr;
    logic [7:0]        host_wdata;
    logic [7:0]        host_rdata;
    logic              host_ack;
    logic              ctx_active;
    logic [CH_W-1:0]   ctx_channel;
    logic [5:0]        func_present;
    logic [31:0]       chan_status;
    logic [CH_W-1:0]   active_channel;
    logic              little_endian_map;
    int                n_errors = 0;
    int                num_checks = 0;

    always #50 clk = ~clk;

    rmdec_host host (.clk(clk), .host_rd(host_rd), .host_wr(host_wr),
        .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .host_ack(host_ack));

    rmdec_top DUT (.clk(clk), .rst_n(rst_n), .byte_order_strap(strap),
        .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_ack(host_ack), .ctx_active(ctx_active),
        .ctx_channel(ctx_channel), .func_present(func_present),
        .chan_status(chan_status), .active_channel(active_channel),
        .little_endian_map(little_endian_map));

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        int         lat;
        host.access(1'b1, a, d, q, lat);
        check("write ack delay", 8'(lat), 8'h02);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        int         lat;
        host.access(1'b0, a, 8'h00, q, lat);
        check("read ack delay", 8'(lat), 8'h02);
        check($sformatf("read of %h", a), q, exp);
    endtask

    task automatic t_reset();
        check("active_channel", 8'(active_channel), 8'h00);
        check("little_endian_map", 8'(little_endian_map), 8'h01);
        rd(8'hec, 8'h00);
        rd(8'h82, 8'h00);
        wr(8'h82, 8'h5a);
    endtask

    task automatic t_banks();
        for (int c = 0; c < 4; c++) begin
            wr(8'hec, 8'(c));
            wr(8'h10, 8'h30 + 8'(c));
        end
        for (int c = 3; c >= 0; c--) begin
            wr(8'hec, 8'(c));
            rd(8'h10, 8'h30 + 8'(c));
            rd(8'h82, 8'h5a);
            rd(8'hec, 8'(c));
            check("active_channel", 8'(active_channel), 8'(c));
        end
    endtask

    task automatic t_ctx();
        @(negedge clk);
        ctx_active  = 1'b1;
        ctx_channel = 2'h2;
        rd(8'h10, 8'h32);
        check("active_channel", 8'(active_channel), 8'h02);
        rd(8'h19, 8'hc2);
        wr(8'h19, 8'hff);
        rd(8'h19, 8'hc2);
        wr(8'h10, 8'h42);
        rd(8'h10, 8'h42);
        @(negedge clk);
        ctx_active = 1'b0;
        rd(8'h10, 8'h30);
    endtask

    task automatic t_alias();
        logic [7:0] val [3] = '{8'ha1, 8'hb1, 8'hc1};
        wr(8'hec, 8'h01);
        for (int m = 0; m < 3; m++) begin
            wr(8'h18, 8'(m));
            wr(8'h1c, val[m]);
        end
        wr(8'hd4, 8'h00);
        for (int m = 0; m < 3; m++) begin
            wr(8'h18, 8'(m));
            rd(8'h1c, val[m]);
        end
        wr(8'h18, 8'h01);
        wr(8'hd4, 8'h5e);
        rd(8'hd4, 8'h5e);
        wr(8'h18, 8'h03);
        rd(8'h1c, 8'h00);
        wr(8'h18, 8'h00);
        rd(8'hd4, 8'h00);
        rd(8'h1c, 8'ha1);
    endtask

    task automatic t_func();
        @(negedge clk);
        func_present = 6'h3d;
        rd(8'h1c, 8'h00);
        wr(8'h1c, 8'hff);
        @(negedge clk);
        func_present = 6'h3e;
        rd(8'h82, 8'h00);
        @(negedge clk);
        func_present = 6'h3f;
        rd(8'h1c, 8'ha1);
    endtask

    task automatic t_map();
        logic [7:0] le [5] = '{8'h10, 8'h13, 8'hc9, 8'hdc, 8'h82};
        logic [7:0] be [5] = '{8'h13, 8'h10, 8'hcb, 8'hde, 8'h81};
        @(negedge clk);
        strap = 1'b0;
        repeat (4) @(negedge clk);
        check("little_endian_map", 8'(little_endian_map), 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(be[i], 8'h60 + 8'(i));
        end
        rd(8'hee, 8'h01);
        rd(8'hec, 8'h00);
        strap = 1'b1;
        repeat (4) @(negedge clk);
        check("little_endian_map", 8'(little_endian_map), 8'h01);
        for (int i = 0; i < 5; i++) begin
            rd(le[i], 8'h60 + 8'(i));
        end
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h00);
        rd(8'h00, 8'h00);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Whole run is 75 accesses; this leaves wide margin
    initial begin
        #(5000 * 100);
        n_errors++;
        summarize();
    end

    initial begin
        rst_n        = 1'b0;
        strap        = 1'b1;
        ctx_active   = 1'b0;
        ctx_channel  = 2'h0;
        func_present = 6'h3f;
        chan_status  = 32'hd3c2_b1a0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_banks();
        t_ctx();
        t_alias();
        t_func();
        t_map();
        summarize();
    end
endmodule // tb
